// file: src/pmc_pkg.sv
package pmc_pkg;
	// register byte addresses (chosen layout)
	localparam logic [7:0] ADDR_SCC    = 8'h00; // system_clock_control
	localparam logic [7:0] ADDR_OSC    = 8'h04; // fast_osc_control
	localparam logic [7:0] ADDR_STATUS = 8'h08; // flags and mode
	localparam logic [7:0] ADDR_WAKE   = 8'h0c; // port_a_wake_enable
	// field positions
	localparam int SCC_SLOW_KEEP = 0;
	localparam int SCC_FAST_KEEP = 1;
	localparam int SCC_CKS_LSB   = 5;
	localparam int OSC_EN        = 0;
	localparam int OSC_STABLE    = 1;
	localparam logic [2:0] CKS_SLOW = 3'h7;
	localparam logic [2:0] CKS_RST  = 3'h0;
	localparam logic [7:0] WAKE_RST = 8'h00;
	// fast oscillator settle time, model default
	localparam int OSC_SETTLE_NS  = 64;
	localparam int CLK_PERIOD_NS  = 8;
	localparam int OSC_SETTLE_CYC =
		(OSC_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

	typedef enum logic [2:0] {
		MODE_FAST  = 3'h0,
		MODE_SLOW  = 3'h1,
		MODE_SLEEP = 3'h2,
		MODE_IDLE_SLOW_ONLY_MODE = 3'h3,
		MODE_IDLE_BOTH_CLOCKS_MODE = 3'h4,
		MODE_IDLE_FAST_ONLY_MODE = 3'h5
	} mode_t;

	// cpu-side request and response signals
	typedef struct packed {
		logic       stop_instr;
		logic       wdt_clear_instr;
		logic       wdt_overflow;
		logic       wdt_enabled;
		logic       irq_request;
		logic       irq_enabled;
		logic       stack_full;
	} cpu_req_t;

	typedef struct packed {
		logic       cpu_run;
		logic       resume_next;
		logic       irq_service;
		logic       pc_sp_reset;
		logic       wdt_counter_clear;
		logic       wdt_run;
	} cpu_rsp_t;
endpackage

// file: src/power_mode_controller.sv
// Implementation choices: the register offsets and the AHB-Lite register port.
`timescale 1ns/1ps
// Operation
// - select code 111 switches to slow clock
// - slow switch completes when slow oscillator stable
// - codes 000-110 pick fast divided by 2^n
// - slow-to-fast waits for fast stable flag
// - stop with keeps 00 enters sleep
// - stop with keeps 01 enters idle_slow_only_mode
// - stop with keeps 11 enters idle_both_clocks_mode
// - stop with keeps 10 enters idle_fast_only_mode
// - low power halts execution, state retained
// - stop sets power-down, clears timeout flag
// - entering low power clears watchdog counter
// - wake on port edge, interrupt, watchdog
// - per-pin wake enable for falling edges
// - power-down flag cleared by reset, wdt clear
// - watchdog wake sets timeout, resets pc/sp
// - pin wake resumes after stop unless an enabled irq with room coincides
// - masked or stack-full irq resumes, stays pending
// - enabled irq with room gets serviced unless a pin wake coincides
// - pre-pending irq cannot wake device
// - keep bits at scc bits 1,0, reset 0
// - fast enable clears then sets stable flag
module power_mode_controller #(
	parameter int PORT_W     = 8,
	parameter int SETTLE_CYC = pmc_pkg::OSC_SETTLE_CYC
) (
	input  wire logic                 hclk,
	input  wire logic                 hresetn,
	input  wire logic                 hsel,
	input  wire logic [31:0]          haddr,
	input  wire logic [1:0]           htrans,
	input  wire logic                 hwrite,
	input  wire logic [2:0]           hsize,
	input  wire logic [31:0]          hwdata,
	input  wire logic                 hready,
	output logic [31:0]               hrdata,
	output logic                      hreadyout,
	output logic                      hresp,
	input  wire pmc_pkg::cpu_req_t    cpu_req,
	input  wire logic                 slow_osc_stable,
	input  wire logic [PORT_W-1:0]    port_a_in,
	output pmc_pkg::cpu_rsp_t         cpu_rsp,
	output logic                      fast_clk_on,
	output logic                      slow_clk_on,
	output logic                      sys_clk_is_slow,
	output logic [2:0]                sys_div_log2,
	output logic [2:0]                op_mode
);
	pmc_pkg::mode_t    mode_q, mode_d;
	logic [2:0]        cks_q, eff_sel_q;
	logic              fast_keep_q, slow_keep_q;
	logic              osc_en_q, osc_stable_q;
	logic [7:0]        settle_cnt_q;
	logic              pdf_q, to_q;
	logic [PORT_W-1:0] wake_en_q, port_prev_q;
	logic              irq_pre_q;
	logic              wait_clk_q;
	logic              ap_valid_q, ap_write_q;
	logic [7:0]        ap_addr_q;
	logic [31:0]       hrdata_q;
	pmc_pkg::cpu_rsp_t rsp_q;
	logic [31:0]       rd_mux;
	logic              slow_run_q, eff_is_slow_q;
	logic [2:0]        div_q;

	// bus decode
	wire ap_take  = hsel && hready && (htrans == pmc_pkg::HTRANS_NONSEQ);
	wire wr_now   = ap_valid_q && ap_write_q;
	wire wr_scc   = wr_now && (ap_addr_q == pmc_pkg::ADDR_SCC);
	wire wr_osc   = wr_now && (ap_addr_q == pmc_pkg::ADDR_OSC);
	wire wr_wake  = wr_now && (ap_addr_q == pmc_pkg::ADDR_WAKE);
	wire rd_take  = ap_take && !hwrite;
	wire [7:0] rd_addr = haddr[7:0];

	wire low_power = (mode_q != pmc_pkg::MODE_FAST) &&
		(mode_q != pmc_pkg::MODE_SLOW);
	wire stop_go   = cpu_req.stop_instr && !low_power && !wait_clk_q;

	// wake sources
	wire [PORT_W-1:0] pin_fall = port_prev_q & ~port_a_in & wake_en_q;
	wire pin_wake  = |pin_fall;
	wire irq_wake  = cpu_req.irq_request && !irq_pre_q;
	wire wdt_wake  = cpu_req.wdt_overflow;
	wire any_wake  = low_power && (pin_wake || irq_wake || wdt_wake);
	wire irq_take  = irq_wake && cpu_req.irq_enabled && !cpu_req.stack_full;

	// clock needed after wake: requested selection
	wire want_slow = (cks_q == pmc_pkg::CKS_SLOW);
	wire src_ok    = want_slow ? slow_osc_stable : osc_stable_q;
	wire osc_need  = osc_en_q || !want_slow || (mode_q == pmc_pkg::MODE_IDLE_BOTH_CLOCKS_MODE)
		|| (mode_q == pmc_pkg::MODE_IDLE_FAST_ONLY_MODE);

	// stop instruction picks mode from keep bits
	always_comb begin
		mode_d = mode_q;
		if (stop_go) begin
			case ({fast_keep_q, slow_keep_q})
				2'b00:   mode_d = pmc_pkg::MODE_SLEEP;
				2'b01:   mode_d = pmc_pkg::MODE_IDLE_SLOW_ONLY_MODE;
				2'b11:   mode_d = pmc_pkg::MODE_IDLE_BOTH_CLOCKS_MODE;
				2'b10:   mode_d = pmc_pkg::MODE_IDLE_FAST_ONLY_MODE;
				default: mode_d = pmc_pkg::MODE_SLEEP;
			endcase
		end else if (any_wake || !low_power) begin
			mode_d = (eff_sel_q == pmc_pkg::CKS_SLOW) ?
				pmc_pkg::MODE_SLOW : pmc_pkg::MODE_FAST;
		end
	end

	// mode state
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			mode_q     <= pmc_pkg::MODE_FAST;
			wait_clk_q <= 1'b0;
		end else begin
			mode_q     <= mode_d;
			wait_clk_q <= (any_wake || wait_clk_q) && !src_ok;
		end
	end

	// control register fields
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cks_q       <= pmc_pkg::CKS_RST;
			fast_keep_q <= 1'b0;
			slow_keep_q <= 1'b0;
			osc_en_q    <= 1'b1;
			wake_en_q   <= '0;
		end else begin
			if (wr_scc) begin
				cks_q       <= hwdata[pmc_pkg::SCC_CKS_LSB +: 3];
				fast_keep_q <= hwdata[pmc_pkg::SCC_FAST_KEEP];
				slow_keep_q <= hwdata[pmc_pkg::SCC_SLOW_KEEP];
			end
			if (wr_osc)
				osc_en_q <= hwdata[pmc_pkg::OSC_EN];
			if (wr_wake)
				wake_en_q <= hwdata[PORT_W-1:0];
		end
	end

	// fast oscillator runs when enabled or needed outside low power, or kept in idle
	wire fast_run = !low_power ? osc_need :
		((mode_q == pmc_pkg::MODE_IDLE_BOTH_CLOCKS_MODE) || (mode_q == pmc_pkg::MODE_IDLE_FAST_ONLY_MODE));
	wire slow_run = !low_power ||
		(mode_q == pmc_pkg::MODE_IDLE_SLOW_ONLY_MODE) || (mode_q == pmc_pkg::MODE_IDLE_BOTH_CLOCKS_MODE);

	// stable flag drops when stopped, rises after settle count
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			osc_stable_q <= 1'b0;
			settle_cnt_q <= 8'h00;
		end else if (!fast_run) begin
			osc_stable_q <= 1'b0;
			settle_cnt_q <= 8'h00;
		end else if (!osc_stable_q) begin
			settle_cnt_q <= settle_cnt_q + 8'h01;
			osc_stable_q <= (settle_cnt_q == 8'(SETTLE_CYC - 1));
		end
	end

	// effective selection moves only once target clock is stable
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			eff_sel_q <= pmc_pkg::CKS_RST;
		else if (want_slow && slow_osc_stable)
			eff_sel_q <= pmc_pkg::CKS_SLOW;
		else if (!want_slow && osc_stable_q)
			eff_sel_q <= cks_q;
	end

	// status flags
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pdf_q <= 1'b0;
			to_q  <= 1'b0;
		end else begin
			if (stop_go) begin
				pdf_q <= 1'b1;
				to_q  <= 1'b0;
			end else begin
				if (cpu_req.wdt_clear_instr)
					pdf_q <= 1'b0;
				if (low_power && wdt_wake)
					to_q <= 1'b1;
			end
		end
	end

	// pin history and interrupt already pending at entry
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			port_prev_q <= '0;
			irq_pre_q   <= 1'b0;
		end else begin
			port_prev_q <= port_a_in;
			if (stop_go)
				irq_pre_q <= cpu_req.irq_request;
			else if (!cpu_req.irq_request)
				irq_pre_q <= 1'b0;
		end
	end

	// cpu response
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			rsp_q <= '0;
		else begin
			rsp_q.cpu_run <= !low_power && !wait_clk_q && !stop_go;
			rsp_q.wdt_counter_clear <= stop_go;
			rsp_q.wdt_run <= cpu_req.wdt_enabled;
			rsp_q.pc_sp_reset <= any_wake && wdt_wake;
			rsp_q.resume_next <= any_wake && !wdt_wake &&
				!irq_take;
			rsp_q.irq_service <= any_wake && !wdt_wake && !pin_wake &&
				irq_take;
		end
	end

	// ahb-lite slave, zero wait states
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ap_valid_q <= 1'b0;
			ap_write_q <= 1'b0;
			ap_addr_q  <= 8'h00;
			hrdata_q   <= 32'h0000_0000;
		end else begin
			ap_valid_q <= ap_take;
			ap_write_q <= hwrite;
			ap_addr_q  <= haddr[7:0];
			if (rd_take)
				hrdata_q <= rd_mux;
		end
	end

	// read data selection by address phase offset
	assign rd_mux =
		(rd_addr == pmc_pkg::ADDR_SCC) ? {24'h0, cks_q, 3'h0,
			fast_keep_q, slow_keep_q} :
		(rd_addr == pmc_pkg::ADDR_OSC) ? {30'h0, osc_stable_q, osc_en_q} :
		(rd_addr == pmc_pkg::ADDR_STATUS) ? {24'h0, eff_sel_q, op_mode,
			to_q, pdf_q} :
		(rd_addr == pmc_pkg::ADDR_WAKE) ? {{(32-PORT_W){1'b0}}, wake_en_q} :
		32'h0000_0000;

	// outputs
	assign hrdata          = hrdata_q;
	assign hreadyout       = 1'b1;
	assign hresp           = 1'b0;
	assign cpu_rsp         = rsp_q;
	assign fast_clk_on     = osc_stable_q;
	assign slow_clk_on     = slow_run_q;
	assign sys_clk_is_slow = eff_is_slow_q;
	assign sys_div_log2    = div_q;
	assign op_mode         = mode_q;

	// registered clock status
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			slow_run_q    <= 1'b1;
			eff_is_slow_q <= 1'b0;
			div_q         <= 3'h0;
		end else begin
			slow_run_q    <= slow_run;
			eff_is_slow_q <= (eff_sel_q == pmc_pkg::CKS_SLOW);
			div_q         <= (eff_sel_q == pmc_pkg::CKS_SLOW) ? 3'h0 :
				eff_sel_q;
		end
	end

	// assertions
	a_stop_sets_pdf: assert property (@(posedge hclk) disable iff (!hresetn)
		stop_go |=> pdf_q && !to_q) else $error("pdf/to not updated on stop");
	a_sleep_entry: assert property (@(posedge hclk) disable iff (!hresetn)
		stop_go && !fast_keep_q && !slow_keep_q |=>
		mode_q == pmc_pkg::MODE_SLEEP) else $error("sleep not entered");
	a_idle_both_clocks_mode_entry: assert property (@(posedge hclk) disable iff (!hresetn)
		stop_go && fast_keep_q && slow_keep_q |=>
		mode_q == pmc_pkg::MODE_IDLE_BOTH_CLOCKS_MODE) else $error("idle_both_clocks_mode not entered");
	a_wdt_clear: assert property (@(posedge hclk) disable iff (!hresetn)
		stop_go |=> cpu_rsp.wdt_counter_clear) else $error("wdt not cleared");
	a_halt_no_run: assert property (@(posedge hclk) disable iff (!hresetn)
		low_power |=> !cpu_rsp.cpu_run) else $error("cpu runs in low power");
	a_wdt_wake_to: assert property (@(posedge hclk) disable iff (!hresetn)
		any_wake && wdt_wake |=> to_q && cpu_rsp.pc_sp_reset)
		else $error("wdt wake without to");
	a_pre_irq_blocks: assert property (@(posedge hclk) disable iff (!hresetn)
		low_power && irq_pre_q && !pin_wake && !wdt_wake |=>
		mode_q == $past(mode_q)) else $error("pending irq woke device");
	a_slow_needs_osc: assert property (@(posedge hclk) disable iff (!hresetn)
		$rose(eff_sel_q == pmc_pkg::CKS_SLOW) |-> $past(slow_osc_stable))
		else $error("slow switch before stable");
	a_fast_needs_stable: assert property (@(posedge hclk) disable iff (!hresetn)
		$fell(eff_sel_q == pmc_pkg::CKS_SLOW) |-> $past(osc_stable_q))
		else $error("fast switch before stable");

	// keeps 01 at stop must land in the slow-only idle mode
	a_idle_slow_only_mode_entry: assert property (@(posedge hclk) disable iff (!hresetn)
		stop_go && !fast_keep_q && slow_keep_q |=>
		mode_q == pmc_pkg::MODE_IDLE_SLOW_ONLY_MODE)
		else $error("idle_slow_only_mode not entered");

	// keeps 10 at stop must land in the fast-only idle mode
	a_idle_fast_only_mode_entry: assert property (@(posedge hclk) disable iff (!hresetn)
		stop_go && fast_keep_q && !slow_keep_q |=>
		mode_q == pmc_pkg::MODE_IDLE_FAST_ONLY_MODE)
		else $error("idle_fast_only_mode not entered");

	// any accepted wake source leaves low power on the next edge
	a_wake_exit: assert property (@(posedge hclk) disable iff (!hresetn)
		any_wake |=>
		!low_power)
		else $error("wake did not leave low power");

	// with no enabled pin edge and no other source the mode holds
	a_pin_hold: assert property (@(posedge hclk) disable iff (!hresetn)
		low_power && !pin_wake && !irq_wake && !wdt_wake |=>
		mode_q == $past(mode_q))
		else $error("woke without enabled source");

	// the watchdog clear instruction drops the power-down flag
	a_wdt_clr_pdf: assert property (@(posedge hclk) disable iff (!hresetn)
		cpu_req.wdt_clear_instr && !stop_go |=>
		!pdf_q)
		else $error("pdf not cleared");

	// a pin wake resumes after the stop instruction
	a_pin_resume: assert property (@(posedge hclk) disable iff (!hresetn)
		any_wake && pin_wake && !wdt_wake && !irq_take |=>
		cpu_rsp.resume_next)
		else $error("pin wake did not resume");

	// a masked or stack-full interrupt resumes without service
	a_irq_held: assert property (@(posedge hclk) disable iff (!hresetn)
		any_wake && irq_wake && !irq_take && !wdt_wake |=>
		cpu_rsp.resume_next && !cpu_rsp.irq_service)
		else $error("held irq handled wrongly");

	// an enabled interrupt with stack room is serviced
	a_irq_service: assert property (@(posedge hclk) disable iff (!hresetn)
		any_wake && irq_take && !wdt_wake && !pin_wake |=>
		cpu_rsp.irq_service)
		else $error("irq not serviced");

	// a stopped fast oscillator never reports stable
	a_stable_drop: assert property (@(posedge hclk) disable iff (!hresetn)
		!fast_run |=>
		!fast_clk_on)
		else $error("stable flag kept while stopped");

	// the core stays halted while the clock source settles
	a_wait_holds: assert property (@(posedge hclk) disable iff (!hresetn)
		wait_clk_q |=>
		!cpu_rsp.cpu_run)
		else $error("core ran before clock stable");

	// fast divider output follows the effective selection
	a_div_follow: assert property (@(posedge hclk) disable iff (!hresetn)
		eff_sel_q != pmc_pkg::CKS_SLOW |=>
		sys_div_log2 == $past(eff_sel_q))
		else $error("divider does not follow select");

	// the timeout flag only rises from a watchdog wake
	a_to_by_wdt: assert property (@(posedge hclk) disable iff (!hresetn)
		$rose(to_q) |->
		$past(wdt_wake))
		else $error("timeout flag set without wdt wake");

	// main scenarios reached
	c_idle_slow_only_mode_seen: cover property (@(posedge hclk)
		mode_q == pmc_pkg::MODE_IDLE_SLOW_ONLY_MODE);
	c_wdt_wake: cover property (@(posedge hclk) cpu_rsp.pc_sp_reset);
	c_sleep_wake: cover property (@(posedge hclk)
		mode_q == pmc_pkg::MODE_SLEEP ##[1:50] mode_q == pmc_pkg::MODE_FAST);
	c_irq_serviced: cover property (@(posedge hclk) cpu_rsp.irq_service);
	c_to_slow: cover property (@(posedge hclk) sys_clk_is_slow);
endmodule // power_mode_controller

// file: testbench/cpu_model.sv
`timescale 1ns/1ps
// far side: slow oscillator and counters of the core's response pulses
module cpu_model #(
	parameter int SLOW_SETTLE = 3
) (
	input  wire logic              hclk,
	input  wire logic              hresetn,
	input  wire pmc_pkg::cpu_rsp_t cpu_rsp,
	input  wire logic              slow_clk_on,
	output logic                   slow_osc_stable
);
	int cnt;
	int n_resume;
	int n_irq;
	int n_pcsp;
	int n_wclr;
	// slow oscillator reports stable only after it has run a while
	assign slow_osc_stable = slow_clk_on && (cnt == SLOW_SETTLE);
	// count settle time and each response pulse the core receives
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt <= 0;
			n_resume <= 0;
			n_irq <= 0;
			n_pcsp <= 0;
			n_wclr <= 0;
		end else begin
			cnt <= !slow_clk_on ? 0 : (cnt < SLOW_SETTLE ? cnt + 1 : cnt);
			n_resume <= n_resume + int'(cpu_rsp.resume_next);
			n_irq <= n_irq + int'(cpu_rsp.irq_service);
			n_pcsp <= n_pcsp + int'(cpu_rsp.pc_sp_reset);
			n_wclr <= n_wclr + int'(cpu_rsp.wdt_counter_clear);
		end
	end
endmodule // cpu_model

// file: testbench/power_mode_controller_tb_top.sv
`timescale 1ns/1ps
module power_mode_controller_tb_top;
	logic              hclk = 1'b0;
	logic              hresetn = 1'b0;
	logic              hsel = 1'b0;
	logic [31:0]       haddr = 32'h0;
	logic [1:0]        htrans = 2'h0;
	logic              hwrite = 1'b0;
	logic [31:0]       hwdata = 32'h0;
	logic [31:0]       hrdata;
	logic              hreadyout;
	logic              hresp_s;
	logic              slow_ok;
	logic              fast_on;
	logic              slow_on;
	logic              is_slow;
	logic [2:0]        div;
	logic [2:0]        op_mode;
	logic [7:0]        pa = 8'hff;
	logic [31:0]       r;
	pmc_pkg::cpu_req_t req = '0;
	pmc_pkg::cpu_rsp_t rsp;
	int                n_fail = 0;
	int                total_checks = 0;
	int                cyc = 0;

	always #4 hclk = ~hclk;

	power_mode_controller #(.SETTLE_CYC(2)) DUT (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
		.hresp(hresp_s), .cpu_req(req), .slow_osc_stable(slow_ok),
		.port_a_in(pa), .cpu_rsp(rsp), .fast_clk_on(fast_on),
		.slow_clk_on(slow_on), .sys_clk_is_slow(is_slow),
		.sys_div_log2(div), .op_mode(op_mode));

	cpu_model P (.hclk(hclk), .hresetn(hresetn), .cpu_rsp(rsp),
		.slow_clk_on(slow_on), .slow_osc_stable(slow_ok));

	task automatic conclude();
		if (n_fail == 0 && total_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// hang guard
	always @(posedge hclk) begin
		cyc++;
		if (cyc == 20000) begin
			n_fail++;
			conclude();
		end
	end

	task automatic chk(input string n, input logic [31:0] e,
			input logic [31:0] s);
		total_checks++;
		if (s !== e) begin
			$display("mismatch %s expected %h seen %h", n, e, s);
			n_fail++;
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge hclk);
	endtask

	// one single ahb transfer, address phase then data phase
	task automatic bus(input logic w, input logic [7:0] a,
			input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= pmc_pkg::HTRANS_NONSEQ;
		haddr <= {24'h0, a};
		hwrite <= w;
		tick(1);
		while (hreadyout !== 1'b1) tick(1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		tick(1);
		while (hreadyout !== 1'b1) tick(1);
		r = hrdata;
	endtask

	task automatic stop_cpu();
		req.stop_instr <= 1'b1;
		tick(1);
		req.stop_instr <= 1'b0;
		tick(3);
	endtask

	// wait for the core to be released, then check fast mode is back
	task automatic wake_run();
		int i;
		i = 0;
		while (rsp.cpu_run !== 1'b1 && i < 60) begin
			tick(1);
			i++;
		end
		chk("cpu_run", 1, rsp.cpu_run);
		chk("op_mode", pmc_pkg::MODE_FAST, op_mode);
		tick(2);
	endtask

	task automatic t_reset();
		bus(0, pmc_pkg::ADDR_SCC, 0);
		chk("scc", 0, r);
		chk("hresp", 0, hresp_s);
		tick(12);
		chk("fast_stable", 1, fast_on);
	endtask

	task automatic t_select();
		for (int c = 0; c < 8; c++) begin
			bus(1, pmc_pkg::ADDR_SCC, c << 5);
			tick(6);
			chk("is_slow", c == 7, is_slow);
			chk("op_mode", c == 7, op_mode);
			if (c < 7) chk("div", c, div);
		end
	endtask

	// fast oscillator off in slow mode, then back to fast
	task automatic t_restart();
		bus(1, pmc_pkg::ADDR_OSC, 0);
		tick(2);
		chk("fast_stable", 0, fast_on);
		bus(1, pmc_pkg::ADDR_SCC, 0);
		tick(1);
		chk("fast_stable", 0, fast_on);
		chk("is_slow", 1, is_slow);
		bus(1, pmc_pkg::ADDR_OSC, 1);
		tick(12);
		chk("is_slow", 0, is_slow);
	endtask

	// every keep-bit combination, woken by an enabled pin
	task automatic t_modes();
		logic [2:0] m [4] = '{3'h2, 3'h3, 3'h5, 3'h4};
		int s;
		int w;
		req.wdt_enabled <= 1'b1;
		bus(1, pmc_pkg::ADDR_WAKE, 1);
		for (int k = 0; k < 4; k++) begin
			s = P.n_resume;
			w = P.n_wclr;
			bus(1, pmc_pkg::ADDR_SCC, k);
			stop_cpu();
			chk("op_mode", m[k], op_mode);
			chk("slow_on", k & 1, slow_on);
			chk("fast_on", k >> 1, fast_on);
			chk("cpu_run", 0, rsp.cpu_run);
			chk("wclr", w + 1, P.n_wclr);
			chk("wdt_run", 1, rsp.wdt_run);
			bus(0, pmc_pkg::ADDR_STATUS, 0);
			chk("to_pdf", 1, r[1:0]);
			pa <= 8'hfd;
			tick(4);
			chk("op_mode", m[k], op_mode);
			pa <= 8'hfc;
			wake_run();
			chk("resume", s + 1, P.n_resume);
			pa <= 8'hff;
		end
		bus(1, pmc_pkg::ADDR_SCC, 0);
	endtask

	task automatic t_wdt();
		int s;
		s = P.n_pcsp;
		stop_cpu();
		req.wdt_overflow <= 1'b1;
		tick(1);
		req.wdt_overflow <= 1'b0;
		wake_run();
		chk("pc_sp", s + 1, P.n_pcsp);
		bus(0, pmc_pkg::ADDR_STATUS, 0);
		chk("to_pdf", 3, r[1:0]);
		req.wdt_clear_instr <= 1'b1;
		tick(1);
		req.wdt_clear_instr <= 1'b0;
		tick(2);
		bus(0, pmc_pkg::ADDR_STATUS, 0);
		chk("pdf", 0, r[0]);
	endtask

	// interrupt masked, stack full, and serviced
	task automatic t_irq();
		int s;
		int q;
		for (int i = 0; i < 3; i++) begin
			s = P.n_resume;
			q = P.n_irq;
			req.irq_enabled <= (i != 0);
			req.stack_full <= (i == 1);
			stop_cpu();
			req.irq_request <= 1'b1;
			wake_run();
			chk("irq_service", q + (i == 2), P.n_irq);
			chk("resume", s + (i != 2), P.n_resume);
			req.irq_request <= 1'b0;
			tick(2);
		end
	endtask

	// a request already pending at stop must not wake
	task automatic t_pending();
		req.irq_request <= 1'b1;
		tick(1);
		stop_cpu();
		tick(4);
		chk("op_mode", pmc_pkg::MODE_SLEEP, op_mode);
		req.irq_request <= 1'b0;
		tick(2);
		pa <= 8'hfe;
		wake_run();
		pa <= 8'hff;
	endtask

	// reset, then the scenarios in turn
	initial begin
		tick(16);
		hresetn <= 1'b1;
		tick(1);
		t_reset();
		t_select();
		t_restart();
		t_modes();
		t_wdt();
		t_irq();
		t_pending();
		conclude();
	end
endmodule // power_mode_controller_tb_top
